//--- logic/nvm_write_ctrl.sv
// In-application nonvolatile write controller with APB register access
//
// The APB register port is this design's own decision.
`include "nvm_write_regs.svh"
module nvm_write_ctrl
  import nvm_write_pkg::*;
#(
  parameter int unsigned WRITE_CYCLES = `WRITE_CYCLES
)
(
  input  wire logic          pclk,          // System clock
  input  wire logic          presetn,       // Async reset, active low
  input  wire logic          psel,          // APB select
  input  wire logic          penable,       // APB enable
  input  wire logic          pwrite,        // APB direction
  input  wire logic [11:0]   paddr,         // APB byte address
  input  wire logic [31:0]   pwdata,        // APB write data
  output logic [31:0]        prdata,        // APB read data
  output logic               pready,        // APB ready
  output logic               pslverr,       // APB error
  input  wire wr_req_t       req,           // Write request from core
  input  wire logic          irq_req,       // Any interrupt request
  input  wire logic          prog_mode,     // External programming mode
  input  wire logic          dev_locked,    // Device lock
  input  wire logic [255:0]  rf_data,       // Register file bytes 0-31
  output logic               core_stall,    // Hold core execution
  output mem_cmd_t           mem_cmd,       // Array command
  output logic [255:0]       mem_block_data // Block data latched
);

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer state, option bytes and status share one packed struct, so a
  // single register stage feeds every output and no pin is reached through logic.
  // A write holds the core for WRITE_CYCLES clocks; the count is loaded with one
  // less than that because the start edge opens the first busy cycle.
  typedef struct packed {
    wr_state_t    st;
    logic [22:0]  cnt;
    logic [7:0]   prot_q;
    logic [7:0]   unprot_q;
    logic [7:0]   status_q;
    logic         stall_q;
    mem_cmd_t     cmd_q;
    logic [`BLOCK_BYTES-1:0][7:0] blk_q; // One entry per block byte
    logic [31:0]  prdata_q;
    logic         pready_q;
    logic         pslverr_q;
  } state_t;

  state_t s_q;
  state_t s_d;
  logic   protect_hit;
  logic   go;
  logic   apb_setup;
  logic   apb_access;
  logic   refuse_write;
  logic   write_done;

  ////////////////////////////////////////////////////////////////////////////
  // Register map helpers

  // Mapped registers answer cleanly except a write to the status register; any other address answers with an error
  function automatic logic reg_known
  (
    input logic [11:0] addr // APB byte address
  );
    logic hit;
    case (addr)
      `FIRST_PROT_PAGE_ADDR,
      `FIRST_UNPROT_PAGE_ADDR,
      `WRITE_STATUS_ADDR:
        hit = 1'b1;
      default:
        hit = 1'b0;
    endcase
    return hit;
  endfunction

  // Only the option bytes take writes; the status register is read-only
  function automatic logic reg_writable
  (
    input logic [11:0] addr // APB byte address
  );
    logic ok;
    ok = (addr == `FIRST_PROT_PAGE_ADDR) || (addr == `FIRST_UNPROT_PAGE_ADDR);
    return ok;
  endfunction

  // Read mux: each register sits in the low byte, upper bytes read zero
  function automatic logic [31:0] reg_read
  (
    input logic [11:0] addr,   // APB byte address
    input logic [7:0]  prot,   // First protected page
    input logic [7:0]  unprot, // First unprotected page
    input logic [7:0]  status  // Write status
  );
    logic [7:0] val;
    case (addr)
      `FIRST_PROT_PAGE_ADDR:
        val = prot;
      `FIRST_UNPROT_PAGE_ADDR:
        val = unprot;
      `WRITE_STATUS_ADDR:
        val = status;
      default:
        val = 8'h00;
    endcase
    return {24'h000000, val};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Write helpers

  // Array byte address: page in the upper byte, then the byte offset or the
  // block index and five zero bits. The index is three bits wide, so a larger
  // block argument aliases onto an existing block instead of raising an error.
  function automatic logic [15:0] target_addr
  (
    input wr_req_t r // Request from the core
  );
    logic [15:0] a;
    if (r.block_go)
      a = {r.page, r.block, 5'h00};
    else
      a = {r.page, r.offset};
    return a;
  endfunction

  // Status after an attempt: success clears both flags, an abort sets only its
  // own flag, so an earlier cause stays visible until a clean write
  function automatic logic [7:0] status_after
  (
    input logic [7:0] cur,        // Status before the event
    input logic       done,       // Write completed
    input logic       prot_abort, // Refused for a protected page
    input logic       irq_abort   // Cut by an interrupt
  );
    logic [7:0] nxt;
    nxt = cur;
    if (done)
      nxt = `STATUS_RESET;
    if (prot_abort)
      nxt[`STAT_PROT_BIT] = 1'b1;
    if (irq_abort)
      nxt[`STAT_ABORT_BIT] = 1'b1;
    return nxt;
  endfunction

  nvm_page_guard u_guard (
    .first_prot   (s_q.prot_q),
    .first_unprot (s_q.unprot_q),
    .page         (req.page),
    .prog_mode    (prog_mode),
    .protect_hit  (protect_hit)
  );

  assign go        = req.byte_go || req.block_go;
  assign apb_setup = psel && !penable && !s_q.pready_q;
  // Access phase of a transfer that was answered at the previous edge
  assign apb_access = psel && penable && s_q.pready_q;

  // A protected page outside programming mode, or a locked device in programming mode, refuses the write
  assign refuse_write = protect_hit || (prog_mode && dev_locked);
  // Count exhausted; an interrupt in the same cycle still wins in the sequencer
  assign write_done   = (s_q.st == ST_WRITE) && (s_q.cnt == 23'h000000);

  ////////////////////////////////////////////////////////////////////////////
  // Next state: write sequencer and APB slave
  always_comb
  begin
    s_d = s_q;
    s_d.cmd_q.start = 1'b0;
    s_d.pready_q = 1'b0;
    s_d.pslverr_q = 1'b0;
    case (s_q.st)
      ST_IDLE:
      begin
        if (go)
        begin
          // Refused attempts leave the array alone and the core running
          if (refuse_write)
            s_d.status_q = status_after(s_q.status_q, 1'b0, 1'b1, 1'b0);
          else
          begin
            s_d.st = ST_WRITE;
            s_d.stall_q = 1'b1;
            s_d.cnt = 23'(WRITE_CYCLES - 1);
            s_d.cmd_q.start = 1'b1;
            s_d.cmd_q.block = req.block_go;
            s_d.cmd_q.addr = target_addr(req);
            s_d.cmd_q.data = req.data;
            if (req.block_go)
              s_d.blk_q = rf_data;
          end
        end
      end
      ST_WRITE:
      begin
        // An interrupt cuts the write short; the array may be left unwritten
        if (irq_req)
        begin
          s_d.st = ST_IDLE;
          s_d.stall_q = 1'b0;
          s_d.status_q = status_after(s_q.status_q, 1'b0, 1'b0, 1'b1);
        end
        else if (write_done)
        begin
          s_d.st = ST_IDLE;
          s_d.stall_q = 1'b0;
          s_d.status_q = status_after(s_q.status_q, 1'b1, 1'b0, 1'b0);
        end
        else
          s_d.cnt = s_q.cnt - 23'h000001;
      end
      default:
        s_d.st = ST_IDLE;
    endcase
    // APB setup: the answer is registered for the access phase; reads have no side effect
    if (apb_setup)
    begin
      s_d.pready_q = 1'b1;
      s_d.prdata_q = reg_read(paddr, s_q.prot_q, s_q.unprot_q, s_q.status_q);
      s_d.pslverr_q = !reg_known(paddr) || (pwrite && !reg_writable(paddr));
    end
    // A write lands at the edge where the master sees pready, never earlier, so a
    // transfer abandoned before its access phase changes nothing
    if (apb_access && pwrite && !s_q.pslverr_q)
    begin
      case (paddr)
        `FIRST_PROT_PAGE_ADDR:
          s_d.prot_q = pwdata[7:0];
        `FIRST_UNPROT_PAGE_ADDR:
          s_d.unprot_q = pwdata[7:0];
        default:
          s_d.pslverr_q = 1'b0; // Refused writes never get here
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q <= '0;
      s_q.st <= ST_IDLE;
      s_q.prot_q <= `PAGE_RESET;
      s_q.unprot_q <= `PAGE_RESET;
      s_q.status_q <= `STATUS_RESET;
    end
    else
      s_q <= s_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from flops
  assign prdata         = s_q.prdata_q;
  assign pready         = s_q.pready_q;
  assign pslverr        = s_q.pslverr_q;
  assign core_stall     = s_q.stall_q;
  assign mem_cmd        = s_q.cmd_q;

  // Block latch to the array, one byte lane per entry of the latch
  for (genvar b = 0; b < `BLOCK_BYTES; b++)
  begin : g_lane
    assign mem_block_data[8*b+7:8*b] = s_q.blk_q[b];
  end

endmodule

//--- logic/nvm_write_regs.svh
// Register offsets, field positions, reset values and timing counts of the nonvolatile write controller
`ifndef NVM_WRITE_REGS_SVH
`define NVM_WRITE_REGS_SVH

// Register indices, and their APB byte addresses at four times the index
`define FIRST_PROT_PAGE_IDX   8'h05
`define FIRST_UNPROT_PAGE_IDX 8'h06
`define WRITE_STATUS_IDX      8'h28
`define FIRST_PROT_PAGE_ADDR   12'h014
`define FIRST_UNPROT_PAGE_ADDR 12'h018
`define WRITE_STATUS_ADDR      12'h0A0

// Reset values and status fields
`define PAGE_RESET     8'h00
`define STATUS_RESET   8'h00
`define STAT_PROT_BIT  1
`define STAT_ABORT_BIT 0

// Write geometry
`define BLOCK_BYTES    32
`define PAGE_BYTES     256

// Write duration: 4.5 ms at 50 ns per clock
`define WRITE_TIME_NS  4500000
`define CLK_PERIOD_NS  50
`define WRITE_CYCLES   (`WRITE_TIME_NS / `CLK_PERIOD_NS)

`endif

//--- logic/nvm_write_pkg.sv
// Types shared by the nonvolatile write controller
package nvm_write_pkg;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_WRITE = 2'b01
  } wr_state_t;

  // Write request from the core
  typedef struct packed {
    logic       byte_go;   // Extended store executed
    logic       block_go;  // Block-set executed
    logic [7:0] page;      // Page from last page select
    logic [7:0] offset;    // Byte offset (byte mode)
    logic [2:0] block;     // Block index (block mode)
    logic [7:0] data;      // Store data (byte mode)
  } wr_req_t;

  // Command to the memory array
  typedef struct packed {
    logic       start;
    logic       block;
    logic [15:0] addr;
    logic [7:0] data;
  } mem_cmd_t;

endpackage

//--- logic/nvm_page_guard.sv
// Protected page range check
module nvm_page_guard
  import nvm_write_pkg::*;
(
  input  wire logic [7:0] first_prot,   // First protected page
  input  wire logic [7:0] first_unprot, // First page after protected range
  input  wire logic [7:0] page,         // Target page
  input  wire logic       prog_mode,    // External programming mode
  output logic            protect_hit   // Target page is protected
);
  logic in_range;

  // Range wraps when the end lies below the start; equal bytes protect nothing
  always_comb
  begin
    if (first_prot == first_unprot)
      in_range = 1'b0;
    else if (first_prot < first_unprot)
      in_range = (page >= first_prot) && (page < first_unprot);
    else
      in_range = (page >= first_prot) || (page < first_unprot);
    protect_hit = in_range && !prog_mode;
  end
endmodule

//--- dv/nvm_core_model.sv
// Core-side model that executes store and block-set instructions
module nvm_core_model
  import nvm_write_pkg::*;
(
  input  wire logic       pclk,       // Clock
  input  wire logic       presetn,    // Reset, active low
  input  wire logic       core_stall, // Core held
  input  wire logic [1:0] issue,      // Bit 0 store, bit 1 block-set
  input  wire logic [7:0] pg,         // Selected page
  input  wire logic [7:0] arg,        // Offset or block argument
  input  wire logic [7:0] dat,        // Store data
  output wr_req_t         req         // Instruction pulses
);
  // A stalled core runs nothing; idle fields toggle so stale values never pass as valid
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      req <= '0;
    else if (|issue && !core_stall)
      req <= {issue[0], issue[1], pg, arg, arg[2:0], dat};
    else
      req <= {2'h0, ~req[26:0]};
endmodule

//--- dv/nvm_write_ctrl_asserts.sv
// Port assertions for the nonvolatile write controller
module nvm_write_ctrl_asserts
  import nvm_write_pkg::*;
#(
  parameter int unsigned WRITE_CYCLES = 10
)
(
  input wire logic         pclk,          // Clock
  input wire logic         presetn,       // Reset
  input wire logic         psel,          // Select
  input wire logic         penable,       // Enable
  input wire logic         pwrite,        // Direction
  input wire logic [11:0]  paddr,         // Address
  input wire logic         pready,        // Ready
  input wire logic         pslverr,       // Error
  input wire wr_req_t      req,           // Core request
  input wire logic         irq_req,       // Interrupt
  input wire logic [255:0] rf_data,       // Source bytes
  input wire logic         core_stall,    // Stall
  input wire mem_cmd_t     mem_cmd,       // Array command
  input wire logic [255:0] mem_block_data // Block latch
);
  default clocking dc @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////
  // Stall length; 17 bits so the full-size count fits too
  logic [16:0] stall_q;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      stall_q <= '0;
    else
      stall_q <= core_stall ? stall_q + 17'h1 : '0;
  a_stall_starts:
    assert property ($rose(core_stall) |-> mem_cmd.start) else $error("stall without start");
  a_start_cause:
    assert property (mem_cmd.start |-> $past(req.byte_go | req.block_go) && core_stall) else $error("bad start");
  a_block_target:
    assert property (mem_cmd.start && mem_cmd.block |-> mem_cmd.addr == {$past(req.page), $past(req.block), 5'h00}
      && mem_block_data == $past(rf_data)) else $error("block target");
  a_byte_target:
    assert property (mem_cmd.start && !mem_cmd.block |-> mem_cmd.addr == {$past(req.page), $past(req.offset)}
      && mem_cmd.data == $past(req.data)) else $error("byte target");
  a_irq_abort:
    assert property (core_stall && irq_req |=> !core_stall) else $error("irq ignored");
  a_stall_max:
    assert property (core_stall |-> stall_q <= WRITE_CYCLES) else $error("stall too long");
  a_stall_full:
    assert property ($fell(core_stall) && !$past(irq_req) |-> stall_q == WRITE_CYCLES) else $error("short");
  a_status_ro:
    assert property (psel && !penable && pwrite && paddr == 12'h0A0 |=> pready && pslverr) else $error("status written");
  c_abort: cover property (core_stall && irq_req);
  c_block: cover property (mem_cmd.start && mem_cmd.block);
  c_byte: cover property (mem_cmd.start && !mem_cmd.block);
endmodule
bind nvm_write_ctrl nvm_write_ctrl_asserts #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr), .req(req),
  .irq_req(irq_req), .rf_data(rf_data), .core_stall(core_stall), .mem_cmd(mem_cmd), .mem_block_data(mem_block_data));

//--- dv/tb_in_app_nvm_write_control.sv
// Self-checking bench for the nonvolatile write controller
`include "nvm_write_regs.svh"
module tb_in_app_nvm_write_control
  import nvm_write_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, irq_req = 0, prog_mode = 0, dev_locked = 0;
  logic pready, pslverr, core_stall;
  logic [1:0] issue = '0;
  logic [7:0] pg = '0, arg = '0, dat = '0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic [33:0] n, notes[$];
  logic [280:0] w, wnotes[$];
  logic [255:0] rf_data = '0, mem_block_data;
  wr_req_t req;
  mem_cmd_t mem_cmd;
  int fails = 0, checks_done = 0, cyc = 0;
  integer seed = 32'h4182;
  initial forever #25 pclk = ~pclk;
  nvm_write_ctrl #(.WRITE_CYCLES(10)) u_nvm_write_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .req(req),
    .irq_req(irq_req), .prog_mode(prog_mode), .dev_locked(dev_locked), .rf_data(rf_data), .core_stall(core_stall),
    .mem_cmd(mem_cmd), .mem_block_data(mem_block_data));
  nvm_core_model u_nvm_core_model (.pclk(pclk), .presetn(presetn), .core_stall(core_stall), .issue(issue),
    .pg(pg), .arg(arg), .dat(dat), .req(req));
  ////////////////////////////////////////
  // APB transfer; request held until pready, expected answer noted first
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic e, input logic [31:0] x);
    @(posedge pclk);
    notes.push_back({~w & ~e, e, x});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // One instruction; interrupts stay off unless asked, then the status is read back
  task automatic nvm(input logic [1:0] k, input logic [7:0] p, input logic i, input logic [1:0] st);
    logic [7:0] a;
    logic [7:0] d;
    logic [31:0] r;
    a = 8'($random(seed));
    d = 8'($random(seed));
    r = $random(seed);
    // In these scenarios a clear bit 1 afterwards means the attempt reached the array
    if (!st[1])
      wnotes.push_back({k[1], p, k[1] ? {a[2:0], 5'h00} : a, d, {8{r}}});
    @(posedge pclk);
    issue <= k;
    pg <= p;
    arg <= a;
    dat <= d;
    rf_data <= {8{r}};
    @(posedge pclk);
    issue <= 2'h0;
    for (int c = 0; c < 18; c++)
    begin
      @(posedge pclk);
      irq_req <= i && c == 4;
    end
    apb(1'b0, `WRITE_STATUS_ADDR, '0, 1'b0, {30'h0, st});
  endtask
  task automatic wrap_up;
    if (notes.size() != 0 || wnotes.size() != 0)
    begin
      fails++;
      $display("[FAIL] %0t expected results never seen", $time);
    end
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Error reads check only the error flag, since their data is not defined
  always @(posedge pclk)
    if (pready === 1'b1)
    begin
      checks_done++;
      if (notes.size() == 0)
      begin
        fails++;
        $display("[FAIL] %0t apb answer with no request", $time);
      end
      else
      begin
        n = notes.pop_front();
        if ({pslverr, n[33] ? prdata : n[31:0]} !== n[32:0])
        begin
          fails++;
          $display("[FAIL] %0t apb answer %h expected %h", $time, {pslverr, prdata}, n[32:0]);
        end
      end
    end
  // Array command check: mode, address and the payload that the mode carries
  always @(posedge pclk)
    if (mem_cmd.start === 1'b1)
    begin
      checks_done++;
      if (wnotes.size() == 0)
      begin
        fails++;
        $display("[FAIL] %0t array write that should have been refused", $time);
      end
      else
      begin
        w = wnotes.pop_front();
        if ({mem_cmd.block, mem_cmd.addr} !== w[280:264] ||
          (w[280] ? mem_block_data !== w[255:0] : mem_cmd.data !== w[263:256]))
        begin
          fails++;
          $display("[FAIL] %0t array command %h expected %h", $time, {mem_cmd.block, mem_cmd.addr}, w[280:264]);
        end
      end
    end
  // Hang guard, well above the few hundred cycles of the sequence
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      fails++;
      wrap_up;
    end
  end
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `FIRST_PROT_PAGE_ADDR, '0, 1'b0, 32'h0);
    apb(1'b0, `FIRST_UNPROT_PAGE_ADDR, '0, 1'b0, 32'h0);
    apb(1'b1, `WRITE_STATUS_ADDR, 32'h3, 1'b1, 32'h0);
    apb(1'b0, 12'h0FC, '0, 1'b1, 32'h0);
    nvm(2'h1, 8'h05, 1'b0, 2'h0);
    apb(1'b1, `FIRST_PROT_PAGE_ADDR, 32'h5, 1'b0, 32'h0);
    apb(1'b1, `FIRST_UNPROT_PAGE_ADDR, 32'h7, 1'b0, 32'h0);
    apb(1'b0, `FIRST_UNPROT_PAGE_ADDR, '0, 1'b0, 32'h7);
    nvm(2'h2, 8'h06, 1'b0, 2'h2);
    apb(1'b0, `WRITE_STATUS_ADDR, '0, 1'b0, 32'h2);
    nvm(2'h1, 8'h05, 1'b0, 2'h2);
    nvm(2'h2, 8'h07, 1'b0, 2'h0);
    nvm(2'h2, 8'h04, 1'b1, 2'h1);
    nvm(2'h1, 8'h04, 1'b0, 2'h0);
    prog_mode <= 1'b1;
    nvm(2'h2, 8'h06, 1'b0, 2'h0);
    dev_locked <= 1'b1;
    nvm(2'h1, 8'h06, 1'b0, 2'h2);
    prog_mode <= 1'b0;
    apb(1'b1, `FIRST_UNPROT_PAGE_ADDR, 32'h5, 1'b0, 32'h0);
    nvm(2'h2, 8'h05, 1'b0, 2'h0);
    // Start above end: the protected range wraps past the top page
    apb(1'b1, `FIRST_PROT_PAGE_ADDR, 32'h7, 1'b0, 32'h0);
    nvm(2'h1, 8'h02, 1'b0, 2'h2);
    nvm(2'h2, 8'h06, 1'b0, 2'h0);
    // Let the monitor take the last answer before the verdict
    @(posedge pclk);
    wrap_up;
  end
endmodule
